// ===== rtl/amd_consts.svh
// Address map constants for the microcontroller and DMA address decoder.
// Assumes inclusion by the package and the decoder module only.
`ifndef AMD_CONSTS_SVH
`define AMD_CONSTS_SVH
// Code and data window bases (upper address nibble groups)
`define AMD_WIN_FIXED      2'h0
`define AMD_WIN_BANK1_LO   2'h1
`define AMD_WIN_BANK2      2'h2
`define AMD_WIN_BANK1_HI   2'h3
// Bank register reset values (16 KB page numbers)
`define AMD_BANK1_RST      6'h01
`define AMD_BANK2_RST      6'h00
// Data space regions
`define AMD_REG_BASE       16'h7F00
`define AMD_RUN_LO         8'h00
`define AMD_RUN_HI         8'h0F
`define AMD_CFG_LO         8'h10
`define AMD_CFG_HI         8'h1F
`define AMD_PWR_LO         8'h20
`define AMD_PWR_HI         8'h2F
`define AMD_BUF_LO         8'h50
`define AMD_BUF_HI         8'h6F
`define AMD_ISA_LO         8'h70
`define AMD_ISA_HI         8'h7F
`define AMD_SER_LO         8'h80
`define AMD_SER_HI         8'h9F
`define AMD_BUF_DATA_ADDR  16'h6000
`define AMD_ISA_MEM_NIB    4'h5
`define AMD_ISA_IO_PAGE    8'h40
`define AMD_LOW_DATA_HI    8'h00
// Bank register offsets inside the power group
`define AMD_BANK2_ADDR     16'h7F28
`define AMD_BANK1_ADDR     16'h7F29
// Packet buffer geometry
`define AMD_PAGES          6'h20
`define AMD_MAX_PAGES      4'hA
`define AMD_PAGE_BITS      7
`endif

// ===== rtl/amd_pkg.sv
// Types shared by the address decoder.
// Assumes amd_consts.svh is on the include path.
package amd_pkg;
  `include "amd_consts.svh"
  // Data space target selected for one access
  typedef enum logic [3:0] {
    AMD_T_NONE  = 4'b0000,
    AMD_T_FLASH = 4'b0001,
    AMD_T_RUN   = 4'b0010,
    AMD_T_CFG   = 4'b0011,
    AMD_T_PWR   = 4'b0100,
    AMD_T_BUF   = 4'b0101,
    AMD_T_ISAR  = 4'b0110,
    AMD_T_SER   = 4'b0111,
    AMD_T_BDATA = 4'b1000,
    AMD_T_ISAM  = 4'b1001,
    AMD_T_ISAIO = 4'b1010,
    AMD_T_LOW   = 4'b1011
  } amd_target_e;
  // Core bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        code;
    logic [15:0] addr;
  } amd_req_s;
  // Debugger observation signals
  typedef struct packed {
    logic t0;
    logic t1;
    logic wake;
    logic core_interrupt_zero;
    logic core_interrupt_one;
  } amd_dbg_s;
endpackage

// ===== rtl/amd_decoder.sv
// Address decoder for microcontroller code/data and DMA engine accesses.
// Assumes one 200 MHz clock, synchronous high reset, pins pre-buffered.
//
// Overview of operation
// - Code 0x0000-0x3FFF maps fixed to flash
// - Windows 0x4000 and 0xC000 use first bank
// - Window 0x8000 uses second bank
// - Each bank picks one of 64 pages
// - Data windows form full 20-bit flash addresses
// - 0x7F00-0x7F9F selects internal register groups
// - 0x6000 reaches buffer data port
// - 0x5000-0x5FFF forwards ISA memory cycles
// - 0x4000-0x40FF forwards ISA I/O cycles
// - Register access keeps flash strobes inactive
// - DMA upper half: 32 one-KB packet windows
// - DMA lower half: 32 KB ISA RAM
// - Packet pages appear contiguous to DMA
// - Both test pins low enter debugger mode
// - Debugger mode repurposes flash pins
// - Reset input raises internal power-on reset
// - Buffer is 32 pages, 10 listed per packet, DMA reaches the first 8
`timescale 1ns/1ps
// Offsets, reset pages and buffer geometry; the guard makes a second include harmless
`include "amd_consts.svh"
module amd_decoder
  import amd_pkg::*;
(
  input  wire logic        core_clk_i,       // System clock
  input  wire logic        srst_i,           // Chip reset input
  input  wire amd_req_s    req_i,            // Core access
  input  wire logic [7:0]  wdata_i,          // Core write data
  input  wire logic [7:0]  isa_mem_base_i,   // ISA memory window base
  input  wire logic [7:0]  isa_io_base_i,    // ISA I/O window base
  input  wire logic [15:0] dma_addr_i,       // DMA engine address
  input  wire logic        dma_req_i,        // DMA access strobe
  input  wire logic [4:0]  pkt_pages_i [10], // Page list of packet
  input  wire logic        manufacturing_test_strap_n_i,
  input  wire logic        chain_test_output_i, // Pin level seen as input
  input  wire amd_dbg_s    dbg_sig_i,        // Internal timer/irq levels
  input  wire logic [19:0] flash_address_bus_i, // Pins seen as inputs
  input  wire logic        flash_read_strobe_n_i,
  input  wire logic        flash_write_strobe_n_i,
  output logic             por_o,            // Internal power-on reset
  output amd_target_e      target_o,         // Selected data target
  output logic [19:0]      flash_address_bus_o,
  output logic             flash_address_oe_n_o, // Low while driven
  output logic             flash_chip_select_n_o,
  output logic             flash_read_strobe_n_o,
  output logic             flash_write_strobe_n_o,
  output logic             chain_test_output_oe_n_o,
  output logic [19:0]      isa_addr_o,       // ISA address
  output logic             isa_mem_cyc_o,    // ISA memory cycle
  output logic             isa_io_cyc_o,     // ISA I/O cycle
  output logic [11:0]      buf_addr_o,       // Packet buffer byte address
  output logic             buf_dma_o,        // DMA reaches buffer
  output logic             dma_isa_ram_o,    // DMA reaches ISA RAM
  output logic             dbg_mode_o,       // Debugger mode active
  output logic [15:0]      dbg_addr_o,       // Debugger address input
  output logic             dbg_rd_o,
  output logic             dbg_wr_o
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Flash page for a 16 KB window
  function automatic logic [5:0] win_page(input logic [1:0] w,
                                          input logic [5:0] b1,
                                          input logic [5:0] b2);
    unique case (w)
      `AMD_WIN_FIXED: win_page = 6'h00;
      `AMD_WIN_BANK2: win_page = b2;
      default:        win_page = b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the test straps
  logic [2:0] manufacturing_test_strap_n_sync;   // Three stages, last two compared
  logic [2:0] tout_sync;
  logic       dbg_reg;

  // Capture straps through three flops
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      manufacturing_test_strap_n_sync <= 3'h7;
      tout_sync  <= 3'h7;
    end
    else
    begin
      manufacturing_test_strap_n_sync <= {manufacturing_test_strap_n_sync[1:0], manufacturing_test_strap_n_i};
      tout_sync  <= {tout_sync[1:0], chain_test_output_i};
    end
  end

  // Debugger mode once both pins are steadily low
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      dbg_reg <= 1'b0;
    else if (manufacturing_test_strap_n_sync[2] == manufacturing_test_strap_n_sync[1] && tout_sync[2] == tout_sync[1])
      dbg_reg <= ~manufacturing_test_strap_n_sync[2] & ~tout_sync[2];
  end
  assign dbg_mode_o = dbg_reg;
  // Test output pin becomes an input in debugger mode
  assign chain_test_output_oe_n_o = dbg_reg;

  ////////////////////////////////////////////////////////////////////
  // Power-on reset: held one cycle past reset input
  logic por_reg;
  always_ff @(posedge core_clk_i)
  begin
    por_reg <= srst_i;
  end
  assign por_o = srst_i | por_reg;

  ////////////////////////////////////////////////////////////////////
  // Flash bank select registers, written through the power group
  logic [5:0] bank1_reg;
  logic [5:0] bank2_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      bank1_reg <= `AMD_BANK1_RST;
      bank2_reg <= `AMD_BANK2_RST;
    end
    else if (req_i.wr && !req_i.code)
    begin
      // Only exact register hits update a bank
      if (req_i.addr == `AMD_BANK1_ADDR)
        bank1_reg <= wdata_i[5:0];
      if (req_i.addr == `AMD_BANK2_ADDR)
        bank2_reg <= wdata_i[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data space target decode
  amd_target_e tgt;
  always_comb
  begin
    tgt = AMD_T_NONE;
    if (req_i.code || req_i.addr[15])
      tgt = AMD_T_FLASH;
    else if (req_i.addr[15:8] == `AMD_REG_BASE >> 8)
    begin
      // Register groups inside 0x7Fxx
      if (req_i.addr[7:0] <= `AMD_RUN_HI)
        tgt = AMD_T_RUN;
      else if (req_i.addr[7:0] <= `AMD_CFG_HI)
        tgt = AMD_T_CFG;
      else if (req_i.addr[7:0] <= `AMD_PWR_HI)
        tgt = AMD_T_PWR;
      else if (req_i.addr[7:0] >= `AMD_BUF_LO && req_i.addr[7:0] <= `AMD_BUF_HI)
        tgt = AMD_T_BUF;
      else if (req_i.addr[7:0] >= `AMD_ISA_LO && req_i.addr[7:0] <= `AMD_ISA_HI)
        tgt = AMD_T_ISAR;
      else if (req_i.addr[7:0] >= `AMD_SER_LO && req_i.addr[7:0] <= `AMD_SER_HI)
        tgt = AMD_T_SER;
    end
    else if (req_i.addr == `AMD_BUF_DATA_ADDR)
      tgt = AMD_T_BDATA;
    else if (req_i.addr[15:12] == `AMD_ISA_MEM_NIB)
      tgt = AMD_T_ISAM;
    else if (req_i.addr[15:8] == `AMD_ISA_IO_PAGE)
      tgt = AMD_T_ISAIO;
    else if (req_i.addr[15:8] == `AMD_LOW_DATA_HI)
      tgt = AMD_T_LOW;
    // Anything else, including 0x1000-0x3FFF, reaches nothing
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs for the core side
  logic active;
  assign active = req_i.rd | req_i.wr;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      target_o               <= AMD_T_NONE;
      flash_address_bus_o    <= 20'h0_0000;
      flash_chip_select_n_o  <= 1'b1;
      flash_read_strobe_n_o  <= 1'b1;
      flash_write_strobe_n_o <= 1'b1;
      isa_addr_o             <= 20'h0_0000;
      isa_mem_cyc_o          <= 1'b0;
      isa_io_cyc_o           <= 1'b0;
    end
    else
    begin
      target_o <= active ? tgt : AMD_T_NONE;
      // Address always shown; page from window bank
      flash_address_bus_o <= {win_page(req_i.addr[15:14], bank1_reg, bank2_reg),
                              req_i.addr[13:0]};
      if (dbg_reg)
      begin
        // Observation signals on chip select pin and top address bits; the address pins stay inputs
        flash_chip_select_n_o         <= dbg_sig_i.t1;
        flash_address_bus_o[19:16]    <= {dbg_sig_i.t0, dbg_sig_i.wake,
                                          dbg_sig_i.core_interrupt_one, dbg_sig_i.core_interrupt_zero};
        flash_read_strobe_n_o         <= 1'b1;
        flash_write_strobe_n_o        <= 1'b1;
      end
      else
      begin
        // Strobes only for real flash targets
        flash_chip_select_n_o  <= ~(active && tgt == AMD_T_FLASH);
        flash_read_strobe_n_o  <= ~(req_i.rd && tgt == AMD_T_FLASH);
        flash_write_strobe_n_o <= ~(req_i.wr && tgt == AMD_T_FLASH);
      end
      isa_mem_cyc_o <= active && tgt == AMD_T_ISAM;
      isa_io_cyc_o  <= active && tgt == AMD_T_ISAIO;
      if (tgt == AMD_T_ISAM)
        isa_addr_o <= {isa_mem_base_i, req_i.addr[11:0]};
      else
        isa_addr_o <= {4'h0, isa_io_base_i, req_i.addr[7:0]};
    end
  end
  // All address pins, the top four included, are inputs in debugger mode
  assign flash_address_oe_n_o = dbg_reg;
  assign dbg_addr_o = flash_address_bus_i[15:0];
  assign dbg_rd_o   = dbg_reg & ~flash_read_strobe_n_i;
  assign dbg_wr_o   = dbg_reg & ~flash_write_strobe_n_i;

  ////////////////////////////////////////////////////////////////////
  // DMA map: upper half to packet windows, lower half to ISA RAM
  logic [3:0] page_idx;  // Page within packet (0 to 7, from dma_addr_i[9:7])
  assign page_idx = 4'(dma_addr_i[9:`AMD_PAGE_BITS]);
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      buf_addr_o    <= 12'h000;
      buf_dma_o     <= 1'b0;
      dma_isa_ram_o <= 1'b0;
    end
    else
    begin
      // Pages past the packet limit are not forwarded
      buf_dma_o     <= dma_req_i & dma_addr_i[15] &
                       (page_idx < `AMD_MAX_PAGES);
      dma_isa_ram_o <= dma_req_i & ~dma_addr_i[15];
      // Scattered pages look contiguous
      if (page_idx < `AMD_MAX_PAGES)
        buf_addr_o <= {pkt_pages_i[page_idx],
                       dma_addr_i[`AMD_PAGE_BITS-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  // Register groups never pulse the flash read strobe
  a_reg_no_strobe: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_i.rd && !req_i.code && req_i.addr[15:8] == 8'h7F && !dbg_reg)
    |=> flash_read_strobe_n_o) else $error("strobe on register access");
  // ISA memory window carries the low twelve address bits
  a_isa_mem_cyc: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_i.rd && !req_i.code && req_i.addr[15:12] == 4'h5)
    |=> isa_mem_cyc_o && isa_addr_o[11:0] == $past(req_i.addr[11:0]))
    else $error("isa memory cycle missing");
  // ISA I/O window raises an I/O cycle
  a_isa_io_cyc: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_i.wr && !req_i.code && req_i.addr[15:8] == 8'h40) |=> isa_io_cyc_o)
    else $error("isa io cycle missing");
  // Lowest code window ignores both banks
  a_fixed_page: assert property (@(posedge core_clk_i) disable iff (srst_i || dbg_reg)
    (req_i.code && req_i.addr[15:14] == 2'h0) |=> flash_address_bus_o[19:14] == 6'h00)
    else $error("fixed page moved");
  // Windows at 0x4000 and 0xC000 follow the first bank
  a_bank1_page: assert property (@(posedge core_clk_i) disable iff (srst_i || dbg_reg)
    (req_i.code && req_i.addr[14])
    |=> flash_address_bus_o[19:14] == $past(bank1_reg)) else $error("bank one ignored");
  // Window at 0x8000 follows the second bank
  a_bank2_page: assert property (@(posedge core_clk_i) disable iff (srst_i || dbg_reg)
    (req_i.code && req_i.addr[15:14] == 2'h2)
    |=> flash_address_bus_o[19:14] == $past(bank2_reg)) else $error("bank two ignored");
  // A data write to the first bank register takes the low six bits
  a_bank_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_i.wr && !req_i.code && req_i.addr == `AMD_BANK1_ADDR)
    |=> bank1_reg == $past(wdata_i[5:0])) else $error("bank one write lost");
  // Reset always restores the default pages
  a_bank1_reset: assert property (@(posedge core_clk_i)
    srst_i |=> bank1_reg == `AMD_BANK1_RST && bank2_reg == `AMD_BANK2_RST)
    else $error("bank reset");
  // Unused data space reaches no target at all
  a_unused_none: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_i.rd && !req_i.code && req_i.addr[15:12] inside {4'h1, 4'h2, 4'h3})
    |=> target_o == AMD_T_NONE && !isa_mem_cyc_o && !isa_io_cyc_o)
    else $error("unused region touched");
  // DMA lower half goes to ISA RAM only
  a_dma_lower: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (dma_req_i && !dma_addr_i[15]) |=> dma_isa_ram_o && !buf_dma_o)
    else $error("dma lower half misrouted");
  // DMA upper half goes to the packet buffer only
  a_dma_upper: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (dma_req_i && dma_addr_i[15]) |=> buf_dma_o && !dma_isa_ram_o)
    else $error("dma upper half misrouted");
  // Power-on reset follows the reset input
  a_por_reset: assert property (@(posedge core_clk_i)
    srst_i |-> por_o) else $error("power-on reset missing");
  // Reset input released: one lingering cycle, then quiet
  sequence s_rst_release;
    srst_i ##1 !srst_i;
  endsequence
  sequence s_por_tail;
    por_o ##1 (srst_i || !por_o);
  endsequence
  a_por_linger: assert property (@(posedge core_clk_i)
    s_rst_release |-> s_por_tail) else $error("power-on reset tail wrong");
  // Both synchronised straps steadily low enter debugger mode
  a_dbg_entry: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (manufacturing_test_strap_n_sync[2:1] == 2'b00 && tout_sync[2:1] == 2'b00) |=> dbg_reg)
    else $error("debugger mode not entered");
  // Flash strobes stay idle while their pins are inputs
  a_dbg_strobes: assert property (@(posedge core_clk_i) disable iff (srst_i)
    dbg_reg |=> flash_read_strobe_n_o && flash_write_strobe_n_o)
    else $error("flash strobes driven in debugger mode");

endmodule

// ===== sim/amd_core_model.sv
// Behavioural microcontroller core and DMA master facing the decoder.
// Assumes one bench process calls its tasks, never two at once.
`timescale 1ns/1ps
module amd_core_model
  import amd_pkg::*;
(
  input  wire logic   core_clk_i, // System clock
  output amd_req_s    req_o,      // Core access
  output logic [7:0]  wdata_o,    // Core write data
  output logic [15:0] dma_addr_o, // DMA address
  output logic        dma_req_o   // DMA strobe
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial
  begin
    req_o      = '0;
    wdata_o    = 8'h00;
    dma_addr_o = 16'h0000;
    dma_req_o  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Core access held for one sampling edge; returns once the answer has landed
  task automatic core_cycle(input logic rd, input logic wr, input logic code,
                            input logic [15:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    req_o   <= '{rd: rd, wr: wr, code: code, addr: addr};
    wdata_o <= data;
    @(posedge core_clk_i);
    // Released lines show the inverse, so a stale value never looks valid
    req_o   <= '{rd: 1'b0, wr: 1'b0, code: 1'b0, addr: ~addr};
    wdata_o <= ~data;
    #1;
  endtask
  // DMA access, same one-edge shape as the core access
  task automatic dma_cycle(input logic [15:0] addr);
    @(posedge core_clk_i);
    dma_addr_o <= addr;
    dma_req_o  <= 1'b1;
    @(posedge core_clk_i);
    dma_addr_o <= ~addr;
    dma_req_o  <= 1'b0;
    #1;
  endtask
endmodule

// ===== sim/amd_decoder_tb.sv
// Self-checking bench for the address decoder.
// Assumes the core model drives requests; bench owns pins, reset and pages.
`timescale 1ns/1ps
module amd_decoder_tb;
  import amd_pkg::*;
  logic        core_clk_i = 1'b0;   // 200 MHz clock
  logic        srst_i     = 1'b1;   // Held at start
  amd_req_s    req;                 // From core model
  logic [7:0]  wdata;               // From core model
  logic [15:0] dma_addr;            // From core model
  logic        dma_req;             // From core model
  logic [7:0]  mem_base = 8'hA7;    // ISA memory window base
  logic [7:0]  io_base  = 8'h3C;    // ISA I/O window base
  logic [4:0]  pages [10];          // Page list of the packet
  logic        strap_n  = 1'b1;     // Test strap, pulled high normally
  logic        chain_in = 1'b1;     // Resolved chain test pin level
  amd_dbg_s    dbg_sig  = '0;       // Timer and interrupt levels
  logic [19:0] fa_in    = 20'h0_0000; // Flash address pins as inputs
  logic        frd_n    = 1'b1;     // Flash read pin as input
  logic        fwr_n    = 1'b1;     // Flash write pin as input
  logic        por, fa_oe_n, fcs_n, frd_o, fwr_o, ct_oe_n, mem_cyc, io_cyc;
  logic        buf_dma, isa_ram, dbg_mode, dbg_rd, dbg_wr;
  amd_target_e target;
  logic [19:0] fa_out, isa_addr;
  logic [11:0] buf_addr;
  logic [15:0] dbg_addr;
  int          mismatches = 0;      // Failed comparisons
  int          samples_checked = 0; // All comparisons
  int          cycles = 0;          // Timeout counter
  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // Page list fixed at time zero, distinct entries so a wrong index shows
  initial
  begin
    for (int i = 0; i < 10; i++) pages[i] = 5'(3 * i + 4);
  end
  amd_core_model amd_core_model_inst (.core_clk_i(core_clk_i), .req_o(req), .wdata_o(wdata),
    .dma_addr_o(dma_addr), .dma_req_o(dma_req));
  amd_decoder amd_decoder_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(req),
    .wdata_i(wdata), .isa_mem_base_i(mem_base), .isa_io_base_i(io_base),
    .dma_addr_i(dma_addr), .dma_req_i(dma_req), .pkt_pages_i(pages),
    .manufacturing_test_strap_n_i(strap_n), .chain_test_output_i(chain_in),
    .dbg_sig_i(dbg_sig), .flash_address_bus_i(fa_in), .flash_read_strobe_n_i(frd_n),
    .flash_write_strobe_n_i(fwr_n), .por_o(por), .target_o(target),
    .flash_address_bus_o(fa_out), .flash_address_oe_n_o(fa_oe_n),
    .flash_chip_select_n_o(fcs_n), .flash_read_strobe_n_o(frd_o),
    .flash_write_strobe_n_o(fwr_o), .chain_test_output_oe_n_o(ct_oe_n),
    .isa_addr_o(isa_addr), .isa_mem_cyc_o(mem_cyc), .isa_io_cyc_o(io_cyc),
    .buf_addr_o(buf_addr), .buf_dma_o(buf_dma), .dma_isa_ram_o(isa_ram),
    .dbg_mode_o(dbg_mode), .dbg_addr_o(dbg_addr), .dbg_rd_o(dbg_rd), .dbg_wr_o(dbg_wr));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared comparison; four-state so an unknown never matches
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, ample for the whole sequence
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Reset for six edges, then power-on reset lingers exactly one cycle
  task automatic t_reset();
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk("por during reset", 20'h1, por);
    chk("read strobe in reset", 20'h1, frd_o);
    srst_i <= 1'b0;
    #1 chk("por after release", 20'h1, por);
    @(posedge core_clk_i);
    #1 chk("por cleared", 20'h0, por);
  endtask
  // Code fetches through the fixed window and both bank defaults
  task automatic t_code_map();
    logic [15:0] a [4] = '{16'h3FFF, 16'h4ABC, 16'h8123, 16'hC123};
    logic [19:0] e [4] = '{20'h0_3FFF, 20'h0_4ABC, 20'h0_0123, 20'h0_4123};
    for (int i = 0; i < 4; i++)
    begin
      amd_core_model_inst.core_cycle(1'b1, 1'b0, 1'b1, a[i], 8'h00);
      chk("code flash address", e[i], fa_out);
      chk("code read strobe", 20'h0, frd_o);
      chk("code chip select", 20'h0, fcs_n);
    end
  endtask
  // Bank writes move windows across the whole flash; registers keep strobes off
  task automatic t_banks();
    amd_core_model_inst.core_cycle(1'b0, 1'b1, 1'b0, 16'h7F29, 8'h05);
    chk("bank write strobe", 20'h1, fwr_o);
    amd_core_model_inst.core_cycle(1'b0, 1'b1, 1'b0, 16'h7F28, 8'h3F);
    amd_core_model_inst.core_cycle(1'b1, 1'b0, 1'b1, 16'hC010, 8'h00);
    chk("bank one page", 20'h1_4010, fa_out);
    amd_core_model_inst.core_cycle(1'b1, 1'b0, 1'b0, 16'hBFFF, 8'h00);
    chk("data top of flash", 20'hF_FFFF, fa_out);
    chk("data flash target", 20'(AMD_T_FLASH), 20'(target));
    t_reset();
    amd_core_model_inst.core_cycle(1'b1, 1'b0, 1'b1, 16'hC010, 8'h00);
    chk("bank one default again", 20'h0_4010, fa_out);
  endtask
  // Register groups and buffer data port at a boundary, plus low data and unused space
  task automatic t_regions();
    logic [15:0] a [12] = '{16'h7F00, 16'h7F0F, 16'h7F10, 16'h7F2F, 16'h7F50, 16'h7F6F,
                            16'h7F70, 16'h7F9F, 16'h6000, 16'h2000, 16'h0042, 16'h1000};
    amd_target_e e [12] = '{AMD_T_RUN, AMD_T_RUN, AMD_T_CFG, AMD_T_PWR, AMD_T_BUF,
                            AMD_T_BUF, AMD_T_ISAR, AMD_T_SER, AMD_T_BDATA, AMD_T_NONE,
                            AMD_T_LOW, AMD_T_NONE};
    for (int i = 0; i < 12; i++)
    begin
      amd_core_model_inst.core_cycle(1'b1, 1'b0, 1'b0, a[i], 8'h00);
      chk("data target", 20'(e[i]), 20'(target));
      chk("inhibited read strobe", 20'h1, frd_o);
      chk("no isa cycle", 20'h0, 20'({mem_cyc, io_cyc}));
    end
  endtask
  // ISA memory and I/O windows carry the window bases
  task automatic t_isa();
    amd_core_model_inst.core_cycle(1'b1, 1'b0, 1'b0, 16'h5FFE, 8'h00);
    chk("isa memory address", 20'hA_7FFE, isa_addr);
    chk("isa memory cycle", 20'h2, 20'({mem_cyc, io_cyc}));
    amd_core_model_inst.core_cycle(1'b0, 1'b1, 1'b0, 16'h40F3, 8'h5A);
    chk("isa io address", 20'h0_3CF3, 20'(isa_addr[15:0]));
    chk("isa io cycle", 20'h1, 20'({mem_cyc, io_cyc}));
  endtask
  // DMA packet windows gather scattered pages; low half goes to ISA RAM
  task automatic t_dma();
    logic [15:0] a [3] = '{16'h8085, 16'h83FF, 16'hFC00};
    logic [11:0] e [3] = '{12'h385, 12'hCFF, 12'h200};
    for (int i = 0; i < 3; i++)
    begin
      amd_core_model_inst.dma_cycle(a[i]);
      chk("buffer address", 20'(e[i]), 20'(buf_addr));
      chk("dma to buffer", 20'h2, 20'({buf_dma, isa_ram}));
    end
    amd_core_model_inst.dma_cycle(16'h7FFF);
    chk("dma to isa ram", 20'h1, 20'({buf_dma, isa_ram}));
  endtask
  // Both test pins low enter debugger mode; flash pins change roles
  task automatic t_debug();
    int n;
    @(posedge core_clk_i);
    strap_n  <= 1'b0;
    chain_in <= 1'b0;
    fa_in    <= 20'h0_1234;
    frd_n    <= 1'b0;       // Debugger reads through the flash read pin
    dbg_sig  <= '{t0: 1'b1, t1: 1'b0, wake: 1'b1, core_interrupt_zero: 1'b0, core_interrupt_one: 1'b1};
    n = 0;
    while (dbg_mode !== 1'b1 && n < 10)
    begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (2) @(posedge core_clk_i);
    #1 chk("debugger mode", 20'h1, dbg_mode);
    chk("chain pin as input", 20'h1, ct_oe_n);
    chk("address pins as input", 20'h1, fa_oe_n);
    chk("debugger address", 20'h0_1234, 20'(dbg_addr));
    chk("timer one on select", 20'h0, fcs_n);
    chk("top address pins", 20'hE, 20'(fa_out[19:16]));
    chk("debugger strobes in", 20'h2, 20'({dbg_rd, dbg_wr}));
    chk("flash strobes idle", 20'h3, 20'({frd_o, fwr_o}));
    @(posedge core_clk_i);
    strap_n  <= 1'b1;
    chain_in <= 1'b1;
    frd_n    <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    #1 chk("debugger mode left", 20'h0, dbg_mode);
    chk("pins driven again", 20'h0, 20'({fa_oe_n, ct_oe_n}));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    t_reset();
    t_code_map();
    t_banks();
    t_regions();
    t_isa();
    t_dma();
    t_debug();
    give_verdict();
  end
endmodule
